// [verilog/dsre_pkg.sv]
package dsre_pkg;
  // plain peripheral space that stripped addresses land in
  localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
  // decorated space: addr[31:29] equals this, op field 010, 011 or 1xx
  localparam logic [2:0]  DEC_REGION   = 3'h2;
  localparam int          REG_HI       = 31;
  localparam int          REG_LO       = 29;
  localparam int          OP_HI        = 28;
  localparam int          OP_LO        = 26;
  localparam logic [2:0]  CODE_PLAIN   = 3'h0;
  localparam logic [2:0]  CODE_OR      = 3'h2;
  localparam logic [2:0]  CODE_XOR     = 3'h3;
  localparam int          INS_BIT      = 28;
  localparam int          POS_HI       = 27;
  localparam int          POS_LO       = 23;
  localparam int          WID_HI       = 22;
  localparam int          WID_LO       = 19;
  localparam int          OFS_HI       = 19;
  localparam int          INS_OFS_HI   = 18;
  localparam logic [1:0]  TRANS_IDLE   = 2'h0;
  localparam logic [1:0]  TRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  SIZE_BYTE    = 3'h0;
  localparam logic [2:0]  SIZE_HALF    = 3'h1;
  localparam logic [2:0]  SIZE_WORD    = 3'h2;
  localparam logic [31:0] CONT_BYTE    = 32'h0000_00ff;
  localparam logic [31:0] CONT_HALF    = 32'h0000_ffff;
  localparam logic [31:0] CONT_WORD    = 32'hffff_ffff;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_OR,
    OP_XOR,
    OP_INS
  } dsre_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RMW,
    ST_WB
  } dsre_state_e;
endpackage : dsre_pkg

// [verilog/dsre_engine.sv]
// Functional notes
// - or store reads, ors operand, writes back
// - xor store reads, xors operand, writes back
// - byte, halfword, word sizes from hsize
// - op code 010 selects or store
// - op code 011 selects xor store
// - or/xor offset is addr 19..0
// - cycle x: stripped address issued as read
// - cycle x+1: captured address issued as write
// - or result of read data captured
// - xor result of read data captured
// - cycle x+2: captured result on write data
// - field insert of w+1 bits at b
// - word field insert at most sixteen bits
// - width code zero inserts one bit
// - addr bit 28 selects field insert
// - field insert uses bit 19 as width
// - field insert offset is addr 18..0
// - other accesses pass straight through
// - decorated region decoded from address and write direction
// - upstream ready low during read-modify phase
// - downstream wait states passed back upstream
module dsre_engine
  import dsre_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [31:0] up_haddr_i,
  input  wire logic [1:0]  up_htrans_i,
  input  wire logic        up_hwrite_i,
  input  wire logic [2:0]  up_hsize_i,
  input  wire logic [3:0]  up_hprot_i,
  input  wire logic [31:0] up_hwdata_i,
  output logic      [31:0] up_hrdata_o,
  output logic             upstream_ready_out_o,
  output logic             up_hresp_o,
  output logic      [31:0] dn_haddr_o,
  output logic      [1:0]  dn_htrans_o,
  output logic             dn_hwrite_o,
  output logic      [2:0]  dn_hsize_o,
  output logic      [3:0]  dn_hprot_o,
  output logic      [31:0] dn_hwdata_o,
  input  wire logic [31:0] dn_hrdata_i,
  input  wire logic        downstream_ready_in_i,
  input  wire logic        dn_hresp_i
);

  // decode purely from the address and direction
  function automatic dsre_op_e dec_op(
    input logic [31:0] a,
    input logic        wr
  );
    dsre_op_e op;
    op = OP_NONE;
    if (wr && a[REG_HI:REG_LO] == DEC_REGION) begin
      if (a[INS_BIT]) begin
        op = OP_INS;
      end else if (a[OP_HI:OP_LO] == CODE_OR) begin
        op = OP_OR;
      end else if (a[OP_HI:OP_LO] == CODE_XOR) begin
        op = OP_XOR;
      end
    end
    return op;
  endfunction : dec_op

  // only offset bits survive; the rest are decoration
  function automatic logic [31:0] strip(
    input logic [31:0] a,
    input dsre_op_e    op
  );
    logic [31:0] r;
    if (op == OP_INS) begin
      r = PERIPH_BASE | {13'h0, a[INS_OFS_HI:0]};
    end else begin
      r = PERIPH_BASE | {12'h0, a[OFS_HI:0]};
    end
    return r;
  endfunction : strip

  // field mask placed on the byte lanes the slave will write
  function automatic logic [31:0] field_mask(
    input logic [31:0] a,
    input logic [2:0]  size
  );
    logic [31:0] ones;
    logic [31:0] cont;
    logic [4:0]  pos;
    logic [4:0]  wid;
    logic [4:0]  lane;
    pos  = a[POS_HI:POS_LO];
    wid  = {1'b0, a[WID_HI:WID_LO]};
    lane = 5'h0;
    cont = CONT_WORD;
    case (size)
      SIZE_BYTE: begin
        cont = CONT_BYTE;
        pos  = {2'h0, a[POS_LO+2:POS_LO]};
        wid  = {2'h0, a[WID_LO+2:WID_LO]};
        lane = {a[1:0], 3'h0};
      end
      SIZE_HALF: begin
        cont = CONT_HALF;
        pos  = {1'h0, a[POS_LO+3:POS_LO]};
        lane = {a[1], 4'h0};
      end
      default: begin
        cont = CONT_WORD;
      end
    endcase
    // 4-bit width code caps a word field at 16 bits
    ones = ~(CONT_WORD << (wid + 5'h1));
    return ((ones << pos) & cont) << lane;
  endfunction : field_mask

  dsre_state_e state;
  dsre_op_e    cap_op;
  logic [31:0] cap_addr;
  logic [2:0]  cap_size;
  logic [3:0]  cap_prot;
  logic [31:0] cap_mask;
  logic [31:0] rmw_data;

  dsre_op_e    new_op;
  logic        up_take;
  logic        start;
  logic [31:0] new_addr;
  logic [31:0] new_mask;
  logic [31:0] merged;

  always_comb begin
    new_op = OP_NONE;
    if (up_htrans_i[1]) begin
      new_op = dec_op(up_haddr_i, up_hwrite_i);
    end
  end

  assign up_take  = up_htrans_i[1] && upstream_ready_out_o;
  assign start    = up_take && new_op != OP_NONE;
  assign new_addr = strip(up_haddr_i, new_op);
  assign new_mask = field_mask(up_haddr_i, up_hsize_i);

  // outputs are combinational so plain traffic sees no added latency
  always_comb begin
    dn_haddr_o           = up_haddr_i;
    dn_htrans_o          = up_htrans_i;
    dn_hwrite_o          = up_hwrite_i;
    dn_hsize_o           = up_hsize_i;
    dn_hprot_o           = up_hprot_i;
    dn_hwdata_o          = up_hwdata_i;
    up_hrdata_o          = dn_hrdata_i;
    upstream_ready_out_o = downstream_ready_in_i;
    up_hresp_o           = dn_hresp_i;
    if (state == ST_RMW) begin
      dn_haddr_o           = cap_addr;
      dn_htrans_o          = TRANS_NONSEQ;
      dn_hwrite_o          = 1'b1;
      dn_hsize_o           = cap_size;
      dn_hprot_o           = cap_prot;
      upstream_ready_out_o = 1'b0;
      up_hresp_o           = 1'b0;
    end else if (up_htrans_i[1] && new_op != OP_NONE) begin
      dn_haddr_o  = new_addr;
      dn_hwrite_o = 1'b0;
    end
    if (state == ST_WB) begin
      dn_hwdata_o = rmw_data;
    end
  end

  // operand comes straight from replicated lanes
  always_comb begin
    case (cap_op)
      OP_OR:   merged = dn_hrdata_i | up_hwdata_i;
      OP_XOR:  merged = dn_hrdata_i ^ up_hwdata_i;
      OP_INS:  merged = (cap_mask & up_hwdata_i)
                      | (~cap_mask & dn_hrdata_i);
      default: merged = dn_hrdata_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_RMW: begin
          if (downstream_ready_in_i) begin
            state <= ST_WB;
          end
        end
        ST_IDLE, ST_WB: begin
          if (start) begin
            state <= ST_RMW;
          end else if (state == ST_WB && !downstream_ready_in_i) begin
            state <= ST_WB;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cap_op   <= OP_NONE;
      cap_addr <= RESET_WORD;
      cap_size <= SIZE_WORD;
      cap_prot <= 4'h0;
      cap_mask <= RESET_WORD;
    end else if (start) begin
      cap_op   <= new_op;
      cap_addr <= new_addr;
      cap_size <= up_hsize_i;
      cap_prot <= up_hprot_i;
      cap_mask <= new_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rmw_data <= RESET_WORD;
    end else if (state == ST_RMW && downstream_ready_in_i) begin
      rmw_data <= merged;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_first;
    start && !dn_hwrite_o && dn_htrans_o == TRANS_NONSEQ;
  endsequence

  sequence s_second;
    dn_hwrite_o && dn_htrans_o == TRANS_NONSEQ
      && !upstream_ready_out_o;
  endsequence

  property p_order;
    start && up_htrans_i == TRANS_NONSEQ |-> s_first ##1 s_second;
  endproperty
  a_order: assert property (p_order)
    else $error("decorated store not read then write");

  property p_addr;
    start |=> dn_haddr_o == $past(new_addr)
      && dn_hsize_o == $past(up_hsize_i);
  endproperty
  a_addr: assert property (p_addr)
    else $error("write phase address or size wrong");

  property p_strip;
    start |-> dn_haddr_o[31:20] == PERIPH_BASE[31:20]
      && (new_op == OP_INS ? dn_haddr_o[OFS_HI] == 1'b0
          : dn_haddr_o[OFS_HI] == up_haddr_i[OFS_HI]);
  endproperty
  a_strip: assert property (p_strip)
    else $error("decoration not stripped");

  property p_pass;
    state != ST_RMW && !(up_htrans_i[1] && new_op != OP_NONE)
      |-> dn_haddr_o == up_haddr_i && dn_hwrite_o == up_hwrite_i;
  endproperty
  a_pass: assert property (p_pass)
    else $error("plain access altered");

  property p_wait;
    state == ST_RMW && !downstream_ready_in_i
      |=> state == ST_RMW && !upstream_ready_out_o;
  endproperty
  a_wait: assert property (p_wait)
    else $error("downstream wait not held");

  property p_wb_ready;
    state == ST_WB |-> upstream_ready_out_o == downstream_ready_in_i;
  endproperty
  a_wb_ready: assert property (p_wb_ready)
    else $error("write-back ready not passed back");

  property p_or;
    state == ST_RMW && downstream_ready_in_i && cap_op == OP_OR
      |=> state == ST_WB
      && dn_hwdata_o == ($past(dn_hrdata_i) | $past(up_hwdata_i));
  endproperty
  a_or: assert property (p_or)
    else $error("or result wrong");

  property p_xor;
    state == ST_RMW && downstream_ready_in_i && cap_op == OP_XOR
      |=> state == ST_WB
      && dn_hwdata_o == ($past(dn_hrdata_i) ^ $past(up_hwdata_i));
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor result wrong");

  property p_ins;
    state == ST_RMW && downstream_ready_in_i && cap_op == OP_INS
      |=> dn_hwdata_o ==
      (($past(cap_mask) & $past(up_hwdata_i))
       | (~$past(cap_mask) & $past(dn_hrdata_i)));
  endproperty
  a_ins: assert property (p_ins)
    else $error("field insert result wrong");

  property p_one_bit;
    start && new_op == OP_INS && up_haddr_i[WID_HI:WID_LO] == 4'h0
      |=> $countones(cap_mask) <= 1;
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("width zero not one bit");

  property p_max16;
    start && new_op == OP_INS |=> $countones(cap_mask) <= 16;
  endproperty
  a_max16: assert property (p_max16)
    else $error("field wider than sixteen bits");

endmodule : dsre_engine

// [bench/dsre_periph_model.sv]
module dsre_periph_model
  import dsre_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hready_o,
  output logic             hresp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic        act;
  logic        wr;
  logic        waited;
  logic [3:0]  idx;
  logic [3:0]  lanes;
  assign hresp_o  = 1'b0;
  // slow mode: one wait state in every data phase
  assign hready_o = !act || !slow_i || waited;
  // not a valid read beat: show inverted data, never stale
  assign hrdata_o = (act && hready_o && !wr) ? mem[idx] : ~mem[idx];
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      act    <= 1'b0;
      waited <= 1'b0;
    end else begin
      waited <= act && !hready_o;
      if (act && hready_o && wr) begin
        for (int k = 0; k < 4; k++) begin
          if (lanes[k]) mem[idx][8*k+:8] <= hwdata_i[8*k+:8];
        end
      end
      if (hready_o) begin
        act   <= htrans_i[1];
        wr    <= hwrite_i;
        idx   <= haddr_i[5:2];
        lanes <= hsize_i == SIZE_WORD ? 4'hf :
                 hsize_i == SIZE_HALF ? 4'h3 << {haddr_i[1], 1'b0} :
                 4'h1 << haddr_i[1:0];
      end
    end
  end
endmodule : dsre_periph_model

// [bench/testbench.sv]
module testbench
  import dsre_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, nrst_i = 0, slow = 0, wr = 0;
  logic        ready, dn_rdy, dn_resp, dn_wr, resp;
  logic [1:0]  trans = 0, dn_trans;
  logic [2:0]  size = 2, dn_size;
  logic [3:0]  prot = 0, dn_prot;
  logic [31:0] addr = 0, wdata = 0, rdata, dn_addr, dn_wdata, dn_rdata;
  logic [31:0] shadow [16];
  int          num_errors = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  dsre_engine i_dsre_engine (.clk_i, .nrst_i, .up_haddr_i(addr),
    .up_htrans_i(trans), .up_hwrite_i(wr), .up_hsize_i(size),
    .up_hprot_i(prot), .up_hwdata_i(wdata), .up_hrdata_o(rdata),
    .upstream_ready_out_o(ready), .up_hresp_o(resp), .dn_haddr_o(dn_addr),
    .dn_htrans_o(dn_trans), .dn_hwrite_o(dn_wr), .dn_hsize_o(dn_size),
    .dn_hprot_o(dn_prot), .dn_hwdata_o(dn_wdata), .dn_hrdata_i(dn_rdata),
    .downstream_ready_in_i(dn_rdy), .dn_hresp_i(dn_resp));
  dsre_periph_model i_dsre_periph_model (.clk_i, .nrst_i, .slow_i(slow),
    .haddr_i(dn_addr), .htrans_i(dn_trans), .hwrite_i(dn_wr),
    .hsize_i(dn_size), .hwdata_i(dn_wdata), .hrdata_o(dn_rdata),
    .hready_o(dn_rdy), .hresp_o(dn_resp));
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  task conclude();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // single transfer, no pipelining; n counts data-phase cycles
  task xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
            input logic [31:0] d, input logic [31:0] ea,
            output logic [31:0] q, output int n);
    logic [3:0] pr;
    logic       dec;
    pr    = 4'($urandom);
    dec   = a !== ea;
    addr  <= a;
    trans <= TRANS_NONSEQ;
    wr    <= w;
    size  <= s;
    prot  <= pr;
    do @(posedge clk_i); while (ready !== 1'b1);
    chk(dn_addr === ea, "addr phase");
    chk(dn_wr === (w && !dec), "addr dir");
    chk(dn_trans === TRANS_NONSEQ, "addr trans");
    chk(dn_size === s && dn_prot === pr, "addr attr");
    trans <= TRANS_IDLE;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n == 1 && dec) begin
        chk(dn_wr === 1'b1 && dn_trans === TRANS_NONSEQ, "wr phase");
        chk(dn_addr === ea && dn_size === s, "wr addr");
        chk(dn_prot === pr, "wr prot");
      end
      chk(resp === 1'b0, "response");
    end while (ready !== 1'b1 && n < 20);
    chk(ready === 1'b1, "data phase hung");
    q = rdata;
  endtask : xfer
  function logic [31:0] exp_word(int op, logic [2:0] s, logic [31:0] a,
                                 logic [31:0] old, logic [31:0] d);
    logic [31:0] lm, fm, nw;
    logic [4:0]  b;
    logic [3:0]  w;
    int          sh;
    sh = s == SIZE_WORD ? 0 : s == SIZE_HALF ? 16 * a[1] : 8 * a[1:0];
    lm = s == SIZE_WORD ? CONT_WORD : s == SIZE_HALF ? CONT_HALF : CONT_BYTE;
    b  = s == SIZE_WORD ? a[27:23] : s == SIZE_HALF ? {1'b0, a[26:23]} :
         {2'h0, a[25:23]};
    w  = s == SIZE_BYTE ? {1'b0, a[21:19]} : a[22:19];
    fm = (32'(((64'h2 << w) - 64'h1) << b) & lm) << sh;
    nw = op == 1 ? old | d : op == 2 ? old ^ d : (old & ~fm) | (d & fm);
    return (old & ~(lm << sh)) | (nw & (lm << sh));
  endfunction : exp_word
  initial begin
    #50000;
    num_errors++;
    $display("Error %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    logic [31:0] a, d, q, ea, r;
    logic [4:0]  p;
    logic [3:0]  w;
    logic [2:0]  s;
    logic        sl;
    int          n, op;
    void'($urandom(63));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      shadow[i] = $urandom;
      a = PERIPH_BASE | 32'(i << 2);
      xfer(a, 1'b1, SIZE_WORD, shadow[i], a, q, n);
      chk(n == 1, "plain stalled");
    end
    for (int i = 0; i < 90; i++) begin
      op = 1 + i % 3;
      s  = 3'((i / 3) % 3);
      sl = 1'($urandom);
      slow <= sl;
      d = $urandom;
      d = s == SIZE_BYTE ? {4{d[7:0]}} :
          s == SIZE_HALF ? {2{d[15:0]}} : d;
      r = $urandom;
      r[1:0] = s == SIZE_WORD ? 2'h0 : s == SIZE_HALF ? {r[1], 1'b0} : r[1:0];
      if (op < 3) begin
        ea = PERIPH_BASE | {12'h0, r[19:0]};
        a  = {3'h2, op == 1 ? CODE_OR : CODE_XOR, r[31:26], r[19:0]};
      end else begin
        ea = PERIPH_BASE | {13'h0, r[18:0]};
        p  = s == SIZE_WORD ? r[24:20] : s == SIZE_HALF ? {1'b1, r[23:20]} :
             {2'h3, r[22:20]};
        // early inserts use width code zero: single-bit fields
        w  = i < 36 ? 4'h0 : r[29:26];
        a  = {3'h2, 1'b1, p, w, r[18:0]};
      end
      xfer(a, 1'b1, s, d, ea, q, n);
      if (!sl) chk(n == 2, "rmw stall length");
      else chk(n > 2, "waits not passed");
      shadow[ea[5:2]] = exp_word(op, s, a, shadow[ea[5:2]], d);
      a = PERIPH_BASE | {26'h0, ea[5:2], 2'h0};
      xfer(a, 1'b0, SIZE_WORD, 32'h0, a, q, n);
      if (op == 1) begin
        chk(q === shadow[ea[5:2]], "or readback");
      end else if (op == 2) begin
        chk(q === shadow[ea[5:2]], "xor readback");
      end else begin
        chk(q === shadow[ea[5:2]], "ins readback");
      end
    end
    // hand-picked: and code and decorated read must pass untouched
    slow <= 1'b0;
    a = {3'h2, 3'h1, 6'h0, 20'h00010};
    d = $urandom;
    xfer(a, 1'b1, SIZE_WORD, d, a, q, n);
    chk(n == 1, "and code stalled");
    shadow[4] = d;
    a = {3'h2, CODE_OR, 6'h0, 20'h00010};
    xfer(a, 1'b0, SIZE_WORD, 32'h0, a, q, n);
    chk(q === shadow[4], "decorated read altered");
    conclude();
  end
endmodule : testbench
